// ==== rtl/isablk_defines.svh ====
`ifndef ISABLK_DEFINES_SVH
`define ISABLK_DEFINES_SVH
// ----------------------------------------------------------------
// I/O port addresses and indices
// ----------------------------------------------------------------
`define ISABLK_PORT_INDEX   16'h0c50
`define ISABLK_PORT_DATA    16'h0c51
`define ISABLK_PORT_GPIO    16'h0c52
`define ISABLK_IDX_SECCTL   8'h80
`define ISABLK_IDX_ADDR_LO  8'h81
`define ISABLK_IDX_ADDR_HI  8'h82
`define ISABLK_IDX_IDXDATA  8'h83
`define ISABLK_IDX_DADDR_LO 8'h84
`define ISABLK_IDX_DADDR_HI 8'h85
`define ISABLK_IDX_WBLK0    8'h86
`define ISABLK_IDX_WBLK3    8'h89
`define ISABLK_HOOD_BIT     4
// ----------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------
`define ISABLK_OFF_SECCTL   12'h200
`define ISABLK_OFF_ADDR_LO  12'h204
`define ISABLK_OFF_ADDR_HI  12'h208
`define ISABLK_OFF_WBLK3    12'h224
`define ISABLK_OFF_STATUS   12'h100
`define ISABLK_OFF_MASK     12'h104
`define ISABLK_OFF_GPIO     12'h108
`define ISABLK_BLK_FUNCS    5
`define ISABLK_RST_BYTE     8'h00
`endif

// ==== rtl/isablk_pkg.sv ====
package isablk_pkg;
   typedef enum logic [1:0] {
      ISABLK_IDLE,
      ISABLK_IDXSEEN,
      ISABLK_BLOCK
   } isablk_st_t;
endpackage : isablk_pkg

// ==== rtl/isablk_regs.sv ====
`timescale 1ns/1ps
`include "isablk_defines.svh"
// Index register file, ports C50h/C51h, indices 80h..89h.
module isablk_regs (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       wr_en,
   input  wire logic [3:0] wr_sel,
   input  wire logic [7:0] wr_data,
   input  wire logic [3:0] rd_sel,
   output logic [7:0]      rd_data,
   output logic [79:0]     all_q
);
   logic [7:0] mem_q [0:9];
   // ----------------------------------------------------------------
   // One byte per index, cleared on reset
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 10; g++) begin : g_byte
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) mem_q[g] <= `ISABLK_RST_BYTE;
            else if (wr_en && wr_sel == 4'(g)) mem_q[g] <= wr_data;
         end
         assign all_q[g*8 +: 8] = mem_q[g];
      end
   endgenerate
   // Registered read port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rd_data <= 8'h00;
      else if (rd_sel < 4'd10) rd_data <= mem_q[rd_sel];
      else rd_data <= 8'h00;
   end
endmodule : isablk_regs

// ==== rtl/isablk_top.sv ====
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "isablk_defines.svh"
module isablk_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] isa_addr,
   input  wire logic [7:0]  isa_data,
   input  wire logic        isa_aen,
   input  wire logic        isa_iowc_n,
   input  wire logic        isa_iorc_n,
   input  wire logic        hood_switch,
   output logic             sio_aen,
   output logic             sio_iowc_n,
   output logic [7:0]       isa_rd_data,
   output logic             isa_rd_valid,
   output logic             irq
);
   import isablk_pkg::*;
   // ----------------------------------------------------------------
   // ISA I/O cycle decode
   // ----------------------------------------------------------------
   logic        iowc_q, idx_q_v;
   logic [7:0]  index_q;
   logic        hood_q;
   logic [1:0]  sts_q, msk_q;
   logic        hood_prev_q;
   logic [79:0] regs;
   logic [7:0]  rd_byte;
   isablk_st_t  st_q, st_d;
   wire io_cyc     = !isa_aen;
   wire wr_strobe  = io_cyc && !isa_iowc_n && iowc_q;
   wire rd_strobe  = io_cyc && !isa_iorc_n;
   wire hit_index  = isa_addr == `ISABLK_PORT_INDEX;
   wire hit_data   = isa_addr == `ISABLK_PORT_DATA;
   wire hit_gpio   = isa_addr == `ISABLK_PORT_GPIO;
   wire idx_in_rng = index_q >= `ISABLK_IDX_SECCTL &&
                     index_q <= `ISABLK_IDX_WBLK3;
   wire [7:0] secctl    = regs[7:0];
   wire [15:0] sio_ia   = {regs[23:16], regs[15:8]};
   wire [15:0] sio_da   = {regs[47:40], regs[39:32]};
   wire [7:0] sio_idxm  = regs[31:24];
   wire [31:0] wblk     = regs[79:48];
   // Match targets: index port, then data port after the watched index
   wire hit_sio_idx = isa_addr == sio_ia;
   wire hit_sio_dat = isa_addr == sio_da;
   wire idx_match   = hit_sio_idx && isa_data == sio_idxm;
   // Any of five function enables plus a write-block bit per low-five-bit data code, or any data value E0h..FFh
   wire [2:0] blk_sel = isa_data[7:5];
   wire func_on = |secctl[`ISABLK_BLK_FUNCS-1:0];
   wire wblk_hit = wblk[{isa_data[4:0]}];
   // Only a write to the data port is held back; reads pass untouched
   wire block_now = wr_strobe && (st_q == ISABLK_IDXSEEN) &&
                    hit_sio_dat && func_on &&
                    (wblk_hit || blk_sel == 3'd7);
   wire reg_wr = wr_strobe && hit_data && idx_in_rng;
   wire [3:0] reg_sel = 4'(index_q - `ISABLK_IDX_SECCTL);
   // ----------------------------------------------------------------
   // Match state machine
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ISABLK_IDLE:    if (wr_strobe && idx_match) st_d = ISABLK_IDXSEEN;
         ISABLK_IDXSEEN: if (block_now) st_d = ISABLK_BLOCK;
                         else if (wr_strobe) st_d = ISABLK_IDLE;
         ISABLK_BLOCK:   if (isa_iowc_n) st_d = ISABLK_IDLE;
      endcase
   end
   // Blocking held for the whole write command to avoid a short glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) st_q <= ISABLK_IDLE;
      else st_q <= st_d;
   end
   wire blocking = (st_d == ISABLK_BLOCK);
   // Gated strobes to the super I/O, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sio_aen    <= 1'b1;
         sio_iowc_n <= 1'b1;
      end else begin
         sio_aen    <= isa_aen | blocking;
         sio_iowc_n <= isa_iowc_n | blocking;
      end
   end
   // Edge detect of the write command, one strobe per cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) iowc_q <= 1'b1;
      else iowc_q <= isa_iowc_n;
   end
   // Index port latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) index_q <= 8'h00;
      else if (wr_strobe && hit_index) index_q <= isa_data;
   end
   assign idx_q_v = idx_in_rng;
   // ----------------------------------------------------------------
   // Hood latch, kept outside the presetn domain
   // ----------------------------------------------------------------
   // Battery-backed: no reset term, so system reset never clears it
   wire gpio_clr  = wr_strobe && hit_gpio && isa_data[`ISABLK_HOOD_BIT];
   wire apb_hclr;
   always_ff @(posedge pclk) begin
      if (hood_switch) hood_q <= 1'b1;
      else if (gpio_clr || apb_hclr) hood_q <= 1'b0;
   end
   // Host reads of 0C52h and C51h
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         isa_rd_data  <= 8'h00;
         isa_rd_valid <= 1'b0;
      end else begin
         isa_rd_valid <= rd_strobe && (hit_gpio || hit_data);
         if (hit_gpio)
            isa_rd_data <= 8'(hood_q) << `ISABLK_HOOD_BIT;
         else
            isa_rd_data <= idx_q_v ? rd_byte : 8'h00;
      end
   end
   // ----------------------------------------------------------------
   // APB slave, zero wait state
   // ----------------------------------------------------------------
   wire apb_acc = psel && penable;
   wire apb_wr  = apb_acc && pwrite;
   wire a_sts   = paddr == `ISABLK_OFF_STATUS;
   wire a_msk   = paddr == `ISABLK_OFF_MASK;
   wire a_gpio  = paddr == `ISABLK_OFF_GPIO;
   // Index registers sit one per aligned word, low byte used
   wire a_reg   = paddr >= `ISABLK_OFF_SECCTL &&
                  paddr <= `ISABLK_OFF_WBLK3 &&
                  paddr[1:0] == 2'b00;
   wire a_ok    = a_sts || a_msk || a_gpio || a_reg;
   assign apb_hclr = apb_wr && a_gpio && pwdata[`ISABLK_HOOD_BIT];
   wire [3:0] apb_idx = paddr[5:2];
   wire [7:0] apb_byte = regs[{apb_idx, 3'b000} +: 8];
   // APB wins a same-cycle clash; the ISA write is then lost
   wire       apb_reg_wr = apb_wr && a_reg;
   wire       any_wr     = reg_wr || apb_reg_wr;
   wire [3:0] any_sel    = apb_reg_wr ? apb_idx : reg_sel;
   wire [7:0] any_data   = apb_reg_wr ? pwdata[7:0] : isa_data;
   isablk_regs u_regs (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (any_wr),
      .wr_sel  (any_sel),
      .wr_data (any_data),
      .rd_sel  (reg_sel),
      .rd_data (rd_byte),
      .all_q   (regs)
   );
   // Events: bit0 hood rising, bit1 blocked write
   logic [1:0] ev;
   always_ff @(posedge pclk or negedge presetn) begin
      // Reset high so a latch still set across reset raises no event
      if (!presetn) hood_prev_q <= 1'b1;
      else hood_prev_q <= hood_q;
   end
   assign ev = {blocking && st_q != ISABLK_BLOCK, hood_q && !hood_prev_q};
   // Set wins over write-one-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sts_q <= 2'b00;
      else if (apb_wr && a_sts) sts_q <= (sts_q & ~pwdata[1:0]) | ev;
      else sts_q <= sts_q | ev;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) msk_q <= 2'b00;
      else if (apb_wr && a_msk) msk_q <= pwdata[1:0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq <= 1'b0;
      else irq <= |(sts_q & msk_q);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !a_ok;
         if (a_sts) prdata <= {30'h0, sts_q};
         else if (a_msk) prdata <= {30'h0, msk_q};
         else if (a_gpio) prdata <= {27'h0, hood_q, 4'h0};
         else if (a_reg && apb_idx < 4'd10) prdata <= {24'h0, apb_byte};
         else prdata <= 32'h0000_0000;
      end
   end
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_block_gate;
      @(posedge pclk) disable iff (!presetn)
      (st_q == ISABLK_BLOCK) |=> sio_iowc_n;
   endproperty
   a_block_gate: assert property (p_block_gate)
      else $error("write reached super I/O while blocked");
   property p_pass;
      @(posedge pclk) disable iff (!presetn)
      (!blocking) |=> sio_iowc_n == $past(isa_iowc_n);
   endproperty
   a_pass: assert property (p_pass)
      else $error("unblocked write not passed through");
   property p_hood_set;
      @(posedge pclk) disable iff (!presetn)
      hood_switch |=> hood_q;
   endproperty
   a_hood_set: assert property (p_hood_set)
      else $error("hood bit not set by switch");
   property p_hood_hold;
      @(posedge pclk) disable iff (!presetn)
      (hood_q && !gpio_clr && !apb_hclr) |=> hood_q;
   endproperty
   a_hood_hold: assert property (p_hood_hold)
      else $error("hood bit lost without clear");
   property p_hood_clr;
      @(posedge pclk) disable iff (!presetn)
      (gpio_clr && !hood_switch) |=> !hood_q;
   endproperty
   a_hood_clr: assert property (p_hood_clr)
      else $error("hood bit not cleared");
   property p_idx_wr;
      @(posedge pclk) disable iff (!presetn)
      (wr_strobe && hit_index) |=> index_q == $past(isa_data);
   endproperty
   a_idx_wr: assert property (p_idx_wr)
      else $error("index port not latched");
   property p_match;
      @(posedge pclk) disable iff (!presetn)
      (st_q == ISABLK_IDLE && wr_strobe && idx_match)
         |=> st_q == ISABLK_IDXSEEN;
   endproperty
   a_match: assert property (p_match)
      else $error("index match missed");
   property p_nofunc;
      @(posedge pclk) disable iff (!presetn)
      (secctl[4:0] == 5'h00) |-> !block_now;
   endproperty
   a_nofunc: assert property (p_nofunc)
      else $error("blocked with no function enabled");
   property p_pready;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready;
   endproperty
   a_pready: assert property (p_pready)
      else $error("APB not answered");
   property p_first_gate;
      @(posedge pclk) disable iff (!presetn)
      block_now |=> sio_aen && sio_iowc_n;
   endproperty
   a_first_gate: assert property (p_first_gate)
      else $error("first blocked cycle reached super I/O");
   property p_arm_block;
      @(posedge pclk) disable iff (!presetn)
      block_now |=> st_q == ISABLK_BLOCK && sts_q[1];
   endproperty
   a_arm_block: assert property (p_arm_block)
      else $error("blocked write not held or not flagged");
   property p_disarm;
      @(posedge pclk) disable iff (!presetn)
      (st_q == ISABLK_IDXSEEN && wr_strobe && !block_now)
         |=> st_q == ISABLK_IDLE;
   endproperty
   a_disarm: assert property (p_disarm)
      else $error("match not dropped after a passed write");
   property p_wblk_bit;
      @(posedge pclk) disable iff (!presetn)
      (wr_strobe && st_q == ISABLK_IDXSEEN && hit_sio_dat &&
       secctl[0] && wblk[isa_data[4:0]]) |-> block_now;
   endproperty
   a_wblk_bit: assert property (p_wblk_bit)
      else $error("write-block bit ignored");
   property p_gpio_rd;
      @(posedge pclk) disable iff (!presetn)
      (rd_strobe && hit_gpio) |=>
         isa_rd_valid && isa_rd_data[`ISABLK_HOOD_BIT] == $past(hood_q);
   endproperty
   a_gpio_rd: assert property (p_gpio_rd)
      else $error("hood bit not returned at general-purpose port");
   property p_data_rd;
      @(posedge pclk) disable iff (!presetn)
      (rd_strobe && hit_data && idx_in_rng) |=>
         isa_rd_valid && isa_rd_data == $past(rd_byte);
   endproperty
   a_data_rd: assert property (p_data_rd)
      else $error("index register read wrong");
   property p_slverr;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !a_ok) |=> pready && pslverr;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("unmapped APB access not refused");
endmodule : isablk_top

// ==== verif/isablk_sio_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------
// Downstream super I/O stand-in
// ------------------------------------------------
module isablk_sio_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic sio_aen,
   input  wire logic sio_iowc_n,
   output int        n_wr
);
   logic iowc_q;
   // Count only writes that really reach the part
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iowc_q <= 1'b1;
         n_wr   <= 0;
      end else begin
         iowc_q <= sio_iowc_n;
         if (iowc_q && !sio_iowc_n && !sio_aen)
            n_wr <= n_wr + 1;
      end
   end
endmodule : isablk_sio_model

// ==== verif/isablk_top_tb.sv ====
`timescale 1ns/1ps
`include "isablk_defines.svh"
module isablk_top_tb;
   // ------------------------------------------------
   // Bench state and instances
   // ------------------------------------------------
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] isa_addr = 16'h0000;
   logic [7:0]  isa_data = 8'h00;
   logic        isa_aen = 1'b1;
   logic        isa_iowc_n = 1'b1;
   logic        isa_iorc_n = 1'b1;
   logic        hood_switch = 1'b0;
   logic [31:0] prdata, rd;
   logic [7:0]  isa_rd_data;
   logic        pready, pslverr, sio_aen, sio_iowc_n, isa_rd_valid, irq;
   logic        err, blk;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          n_wr, n0, i;
   logic [7:0]  ctl_tbl [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
                                8'h01, 8'h01, 8'h00};
   logic [7:0]  dat_tbl [8] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02,
                                8'h03, 8'he0, 8'h02};

   isablk_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .isa_addr(isa_addr), .isa_data(isa_data), .isa_aen(isa_aen),
      .isa_iowc_n(isa_iowc_n), .isa_iorc_n(isa_iorc_n),
      .hood_switch(hood_switch), .sio_aen(sio_aen),
      .sio_iowc_n(sio_iowc_n), .isa_rd_data(isa_rd_data),
      .isa_rd_valid(isa_rd_valid), .irq(irq));
   isablk_sio_model i_sio (.pclk(pclk), .presetn(presetn),
      .sio_aen(sio_aen), .sio_iowc_n(sio_iowc_n), .n_wr(n_wr));

   // 40 MHz clock
   initial begin
      forever #12.5 pclk = ~pclk;
   end

   // ------------------------------------------------
   // Tasks
   // ------------------------------------------------
   task automatic final_report;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   task automatic chk(input string what, logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk

   // APB master, request held until pready is sampled
   task automatic apb(input logic wr, logic [11:0] a, logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (k == 16) begin
         n_fail++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // ISA cycle; idle lines flipped so stale values never match
   task automatic isa(input logic wr, logic [15:0] a, logic [7:0] d);
      int k;
      rd = 32'hx;
      isa_addr <= a;
      isa_data <= d;
      isa_aen <= 1'b0;
      isa_iowc_n <= !wr;
      isa_iorc_n <= wr;
      for (k = 0; k < 6; k++) begin
         @(posedge pclk);
         if (!wr && isa_rd_valid === 1'b1)
            rd = {24'h000000, isa_rd_data};
         if (k == 2) begin
            isa_iowc_n <= 1'b1;
            isa_iorc_n <= 1'b1;
            isa_aen <= 1'b1;
            isa_addr <= ~a;
            isa_data <= ~d;
         end
      end
   endtask : isa

   task automatic ireg(input logic [7:0] idx, logic [7:0] v);
      isa(1'b1, `ISABLK_PORT_INDEX, idx);
      isa(1'b1, `ISABLK_PORT_DATA, v);
   endtask : ireg

   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      chk("sio_aen rst", sio_aen, 32'h1);
      chk("sio_iowc_n rst", sio_iowc_n, 32'h1);
      presetn <= 1'b1;
      // Hood latch powers up unknown, so clear it first
      apb(1'b1, `ISABLK_OFF_GPIO, 32'h10);
      apb(1'b1, `ISABLK_OFF_STATUS, 32'h3);
      for (i = 0; i < 10; i++) begin
         apb(1'b1, `ISABLK_OFF_SECCTL + 12'(i * 4), 32'h5a ^ 32'(i));
         apb(1'b0, `ISABLK_OFF_SECCTL + 12'(i * 4), 32'h0);
         chk("idx reg", rd, 32'h5a ^ 32'(i));
      end
      apb(1'b0, 12'h0f0, 32'h0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      ireg(`ISABLK_IDX_IDXDATA, 8'ha5);
      isa(1'b0, `ISABLK_PORT_DATA, 8'h00);
      chk("c51 read", rd, 32'ha5);
      // Guard index 07h at 2Eh/2Fh, data code 2 blocked
      ireg(`ISABLK_IDX_ADDR_LO, 8'h2e);
      ireg(`ISABLK_IDX_ADDR_HI, 8'h00);
      ireg(`ISABLK_IDX_IDXDATA, 8'h07);
      ireg(`ISABLK_IDX_DADDR_LO, 8'h2f);
      ireg(`ISABLK_IDX_DADDR_HI, 8'h00);
      for (i = 0; i < 4; i++)
         ireg(`ISABLK_IDX_WBLK0 + 8'(i), (i == 0) ? 8'h04 : 8'h00);
      apb(1'b1, `ISABLK_OFF_MASK, 32'h3);
      for (i = 0; i < 8; i++) begin
         blk = (i < 5 || i == 6);
         ireg(`ISABLK_IDX_SECCTL, ctl_tbl[i]);
         n0 = n_wr;
         isa(1'b1, 16'h002e, 8'h07);
         isa(1'b1, 16'h002f, dat_tbl[i]);
         chk("sio writes", n_wr - n0, blk ? 1 : 2);
         chk("blk irq", irq, 32'(blk));
         apb(1'b1, `ISABLK_OFF_STATUS, 32'h2);
      end
      // Cover off, then refit, reset, and software clear
      hood_switch <= 1'b1;
      repeat (5) @(posedge pclk);
      chk("hood irq", irq, 32'h1);
      hood_switch <= 1'b0;
      isa(1'b0, `ISABLK_PORT_GPIO, 8'h00);
      chk("hood refit", rd[4], 32'h1);
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `ISABLK_OFF_GPIO, 32'h0);
      chk("hood after rst", rd[4], 32'h1);
      isa(1'b1, `ISABLK_PORT_GPIO, 8'h10);
      isa(1'b0, `ISABLK_PORT_GPIO, 8'h00);
      chk("hood cleared", rd[4], 32'h0);
      final_report();
   end
endmodule : isablk_top_tb
